// File: rtl/vit_pkg.sv
// Package for the vectored interrupt block with free-running timer.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package vit_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ       = 100;
    localparam int          TICK_MHZ      = 1;
    localparam int          TICK_DIV      = CLK_MHZ / TICK_MHZ;
    localparam logic [6:0]  TICK_LAST     = 7'(TICK_DIV - 1);
    localparam int          TMR_W         = 12;
    localparam int          TAP_128US     = 6;
    localparam int          TAP_1MS       = 9;

    // ------------------------------------------------------------
    // Request numbering (vector order, 0 highest priority)
    // ------------------------------------------------------------
    localparam int          NREQ          = 11;
    localparam int          REQ_BUSRST    = 0;
    localparam int          REQ_T128      = 1;
    localparam int          REQ_T1MS      = 2;
    localparam int          REQ_EP0       = 3;
    localparam int          NEP           = 5;
    localparam int          REQ_SINK      = 8;
    localparam int          REQ_GPIO      = 9;
    localparam int          REQ_SER       = 10;
    localparam int          NGPORT        = 4;
    localparam int          NSINK         = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_TMR_LO    = 12'h000;
    localparam logic [11:0] OFS_TMR_HI    = 12'h004;
    localparam logic [11:0] OFS_REQ_EN    = 12'h008;
    localparam logic [11:0] OFS_PENDING   = 12'h00C;
    localparam logic [11:0] OFS_SINK_EN   = 12'h010;
    localparam logic [11:0] OFS_SINK_POL  = 12'h014;
    localparam logic [11:0] OFS_GPIO_EN   = 12'h018;
    localparam logic [11:0] OFS_GPIO_POL  = 12'h01C;
    localparam logic [31:0] RST_ZERO      = 32'h00000000;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } vit_apb_rsp_t;

    typedef struct packed {
        logic              irq;
        logic [3:0]        vector;
    } vit_core_req_t;

endpackage

// File: rtl/vit_top.sv
// Vectored interrupt collector with a 12-bit free-running timer.
// Assumes inputs synchronous to i_clock, APB slave with zero wait states,
// and a core that pulses i_ack with i_ack_vec when it takes a vector.
// Register reads are taken at the setup edge; writes land at the access
// edge at which the master sees pready high.
// Pin inputs are levels; edges are found against the last sampled value.
`timescale 1ns/1ns

// Operation
// - A 12-bit counter advances once per microsecond from a 1 MHz tick and wraps on its own.
// - Reading the low eight counter bits copies the upper four bits into a hidden hold register.
// - Reading the upper four counter bits returns the hold register, not the live count.
// - Counter bit 6 and bit 9 rising raise the 128 us and 1.024 ms requests when enabled.
// - Eleven requests are each maskable and each send the core to its own vector.
// - Sources are bus reset, two timer taps, five endpoints, sink port, pins and serial master.
// - An endpoint request rises on host data written or packet sent to the host.
// - A per-pin mask selects which sink-port pins feed the sink request.
// - A per-pin mask selects which general pins feed the pin request.
// - Each sink-port pin has its own trigger edge select.
// - General pins take their trigger edge per port from the port configuration.
// - A trigger edge is rising, zero to one, or falling, one to zero.
// - All enabled general pin events merge onto one request with one vector.
module vit_top
    import vit_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    input  wire logic        i_bus_reset,
    input  wire logic [4:0]  i_ep_rx_done,
    input  wire logic [4:0]  i_ep_tx_done,
    input  wire logic [7:0]  i_sink_pins,
    input  wire logic [31:0] i_gpio_pins,
    input  wire logic        i_ser_event,
    input  wire logic        i_ack,
    input  wire logic [3:0]  i_ack_vec,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq,
    output logic [3:0]       o_vector
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state lives in one packed struct: one always_comb builds
    // the next copy and one always_ff registers it, so every output
    // comes straight from a flip-flop.
    typedef struct packed {
        logic [6:0]        div;
        logic [11:0]       count;
        logic [3:0]        hold;
        logic [NREQ-1:0]   req_en;
        logic [NREQ-1:0]   pending;
        logic [7:0]        sink_en;
        logic [7:0]        sink_pol;
        logic [31:0]       gpio_en;
        logic [3:0]        gpio_pol;
        logic [7:0]        sink_prev;
        logic [31:0]       gpio_prev;
        vit_apb_rsp_t      rsp;
        vit_core_req_t     core;
    } vit_state_t;

    vit_state_t st;
    vit_state_t next_st;

    // Byte-lane merge for a write
    function automatic logic [31:0] vit_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Edge qualifier: pol high means rising, low means falling
    function automatic logic vit_edge(input logic prev, input logic cur, input logic pol);
        return pol ? (!prev && cur) : (prev && !cur);
    endfunction

    // Address decode: high for every mapped register word
    function automatic logic vit_mapped(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            OFS_TMR_LO, OFS_TMR_HI, OFS_REQ_EN, OFS_PENDING:
            begin
                hit = 1'b1;
            end
            OFS_SINK_EN, OFS_SINK_POL, OFS_GPIO_EN, OFS_GPIO_POL:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Edge detection on pins
    // ------------------------------------------------------------
    // A pin edge is only seen while its enable bit is set; after reset
    // the last sampled value is zero and all masks are off.
    logic [7:0]  sink_hit;
    logic [31:0] gpio_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NSINK; gi++)
        begin : g_sink
            // Per-pin polarity and mask
            assign sink_hit[gi] = st.sink_en[gi]
                                  && vit_edge(st.sink_prev[gi], i_sink_pins[gi],
                                              st.sink_pol[gi]);
        end
        for (gi = 0; gi < 32; gi++)
        begin : g_gpio
            // Per-port polarity, per-pin mask
            assign gpio_hit[gi] = st.gpio_en[gi]
                                  && vit_edge(st.gpio_prev[gi], i_gpio_pins[gi],
                                              st.gpio_pol[gi/8]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic [11:0]     next_count_w;
    logic [NREQ-1:0] events;
    logic [NREQ-1:0] taken;
    logic            rd_acc;
    logic            wr_acc;
    logic [3:0]      best;
    logic            found;
    logic            setup_ph;
    logic            wr_take;

    always_comb
    begin
        next_st = st;
        rd_acc = i_psel && i_penable && !i_pwrite;
        wr_acc = i_psel && i_penable && i_pwrite;

        // Microsecond tick and free-running count
        // The divider runs from reset; the count wraps on its own and
        // software never loads it.
        next_count_w = st.count;
        if (st.div == TICK_LAST)
        begin
            next_st.div = 7'h00;
            next_count_w = st.count + 12'h001;
        end
        else
        begin
            next_st.div = st.div + 7'h01;
        end
        next_st.count = next_count_w;

        // Source events
        // Level inputs count once per high cycle; the timer taps
        // fire when their count bit rises.
        events = '0;
        events[REQ_BUSRST] = i_bus_reset;
        events[REQ_T128] = !st.count[TAP_128US] && next_count_w[TAP_128US];
        events[REQ_T1MS] = !st.count[TAP_1MS] && next_count_w[TAP_1MS];
        for (int e = 0; e < NEP; e++)
        begin
            events[REQ_EP0 + e] = i_ep_rx_done[e] || i_ep_tx_done[e];
        end
        events[REQ_SINK] = |sink_hit;
        events[REQ_GPIO] = |gpio_hit;
        events[REQ_SER] = i_ser_event;
        next_st.sink_prev = i_sink_pins;
        next_st.gpio_prev = i_gpio_pins;

        // Pending: set wins over acknowledge, so an event in the same
        // cycle as the ack of its own vector is not lost.
        // A request disabled when its event comes is not recorded.
        taken = '0;
        if (i_ack && (i_ack_vec < 4'(NREQ)))
        begin
            taken[i_ack_vec] = 1'b1;
        end
        next_st.pending = (st.pending & ~taken) | (events & st.req_en);

        // Highest-priority pending request to the core; index 0 wins.
        // Built from the next pending set, so irq and vector move
        // together on the edge that sets or clears a flag.
        best = 4'h0;
        found = 1'b0;
        for (int r = NREQ - 1; r >= 0; r--)
        begin
            if (next_st.pending[r])
            begin
                best = 4'(r);
                found = 1'b1;
            end
        end
        next_st.core.irq = found;
        next_st.core.vector = best;

        // ------------------------------------------------------------
        // APB setup edge: latch the answer
        // ------------------------------------------------------------
        // The answer stands for the first access cycle only, so the
        // master sees pready high at its first access edge.
        setup_ph = i_psel && !i_penable;
        next_st.rsp.pready = setup_ph;
        next_st.rsp.pslverr = setup_ph && !vit_mapped(i_paddr);
        next_st.rsp.prdata = RST_ZERO;

        // Read word taken from the state at the setup edge
        if (setup_ph && !i_pwrite)
        begin
            case (i_paddr)
                OFS_TMR_LO:
                begin
                    next_st.rsp.prdata = {24'h000000, st.count[7:0]};
                end
                OFS_TMR_HI:
                begin
                    next_st.rsp.prdata = {28'h0000000, st.hold};
                end
                OFS_REQ_EN:
                begin
                    next_st.rsp.prdata = {21'h00000, st.req_en};
                end
                OFS_PENDING:
                begin
                    next_st.rsp.prdata = {21'h00000, st.pending};
                end
                OFS_SINK_EN:
                begin
                    next_st.rsp.prdata = {24'h000000, st.sink_en};
                end
                OFS_SINK_POL:
                begin
                    next_st.rsp.prdata = {24'h000000, st.sink_pol};
                end
                OFS_GPIO_EN:
                begin
                    next_st.rsp.prdata = st.gpio_en;
                end
                OFS_GPIO_POL:
                begin
                    next_st.rsp.prdata = {28'h0000000, st.gpio_pol};
                end
                default:
                begin
                    next_st.rsp.prdata = RST_ZERO;
                end
            endcase
        end

        // Freeze the upper count bits on a low read, so that a carry
        // between the two reads cannot tear the 12-bit value
        if (setup_ph && !i_pwrite && (i_paddr == OFS_TMR_LO))
        begin
            next_st.hold = st.count[11:8];
        end

        // ------------------------------------------------------------
        // APB access edge: a write lands with pready seen high
        // ------------------------------------------------------------
        // Address and data are still held here; refused and
        // read-only targets are left untouched.
        wr_take = wr_acc && st.rsp.pready && !st.rsp.pslverr;
        if (wr_take)
        begin
            case (i_paddr)
                OFS_REQ_EN:
                begin
                    next_st.req_en = NREQ'(vit_merge({21'h00000, st.req_en}, i_pwdata, i_pstrb));
                end
                OFS_SINK_EN:
                begin
                    next_st.sink_en = 8'(vit_merge({24'h000000, st.sink_en}, i_pwdata, i_pstrb));
                end
                OFS_SINK_POL:
                begin
                    next_st.sink_pol = 8'(vit_merge({24'h000000, st.sink_pol}, i_pwdata, i_pstrb));
                end
                OFS_GPIO_EN:
                begin
                    next_st.gpio_en = vit_merge(st.gpio_en, i_pwdata, i_pstrb);
                end
                OFS_GPIO_POL:
                begin
                    next_st.gpio_pol = 4'(vit_merge({28'h0000000, st.gpio_pol}, i_pwdata, i_pstrb));
                end
                default:
                begin
                    // Timer and pending words ignore writes
                    next_st.req_en = st.req_en;
                end
            endcase
        end

        // The answer ends with the access phase
        if (rd_acc || wr_acc)
        begin
            next_st.rsp.pready = 1'b0;
            next_st.rsp.pslverr = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Asynchronous clear to zero, registered copy on every edge
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    // No logic between the state register and the pins
    assign o_prdata = st.rsp.prdata;
    assign o_pready = st.rsp.pready;
    assign o_pslverr = st.rsp.pslverr;
    assign o_irq = st.core.irq;
    assign o_vector = st.core.vector;

endmodule

// File: test/test_vit_top.sv
// Bench for vit_top with a core model.
// Assumes zero-wait APB and a one-cycle ack.
`timescale 1ns/1ns
module test_vit_top
    import vit_pkg::*;
;
    localparam logic [31:0] M      = 32'hFFFFFFFF;
    localparam logic [7:0]  SP[6]  = '{8'h08, 8'h00, 8'h20, 8'h00, 8'h01, 8'h00};
    localparam bit          SX[6]  = '{1, 0, 0, 1, 0, 0};
    logic        i_clock = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic        i_bus_reset = 0, i_ser_event = 0, i_ack, o_pready, o_pslverr, o_irq;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, i_gpio_pins = '0, o_prdata, r, a;
    logic [4:0]  i_ep_rx_done = '0, i_ep_tx_done = '0;
    logic [7:0]  i_sink_pins = '0;
    logic [3:0]  i_pstrb = 4'hF, i_ack_vec, o_vector;
    logic [1:0]  dly = '0;
    logic [64:0] e, exp_rd[$];
    logic [3:0]  exp_vec[$];
    int          num_errors = 0, checks = 0, cyc = 0, seed = 32'h3E355CBC, p;
    vit_top i_dut (.i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .i_bus_reset,
        .i_ep_rx_done, .i_ep_tx_done, .i_sink_pins, .i_gpio_pins, .i_ser_event, .i_ack, .i_ack_vec, .o_prdata,
        .o_pready, .o_pslverr, .o_irq, .o_vector);
    vit_core_model i_core (.i_clock, .i_rstn, .i_irq(o_irq), .i_vector(o_vector), .i_delay(dly), .o_ack(i_ack),
        .o_ack_vec(i_ack_vec));
    initial forever #5 i_clock = ~i_clock;
    // ----------
    // Tasks
    // ----------
    task automatic chk(input bit ok, input string m);
        checks++;
        if (!ok)
        begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One transfer; x is {error, compare mask, data}
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [64:0] x);
        exp_rd.push_back(x);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, ad, d};
        @(posedge i_clock);
        i_penable <= 1'b1;
        @(posedge i_clock);
        while (o_pready !== 1'b1) @(posedge i_clock);
        r = o_prdata;
        {i_psel, i_penable} <= 2'b00;
        @(posedge i_clock);
    endtask
    task automatic fire(input logic b, input logic [4:0] x, input logic [4:0] y, input logic s);
        {i_bus_reset, i_ep_rx_done, i_ep_tx_done, i_ser_event} <= {b, x, y, s};
        @(posedge i_clock);
        {i_bus_reset, i_ep_rx_done, i_ep_tx_done, i_ser_event} <= '0;
        @(posedge i_clock);
    endtask
    task automatic drain(input int lim);
        int n = 0;
        while (exp_vec.size() > 0 && n++ < lim) @(posedge i_clock);
        repeat (4) @(posedge i_clock);
        chk(exp_vec.size() == 0, "vector missing");
    endtask
    // Compare answers and taken vectors with the oldest notes
    always @(posedge i_clock)
    begin
        if (o_pready === 1'b1)
        begin
            e = exp_rd.pop_front();
            chk({o_pslverr, o_prdata & e[63:32]} === {e[64], e[31:0]}, "bus answer");
        end
        if (i_ack === 1'b1) chk(exp_vec.size() > 0 && i_ack_vec === exp_vec.pop_front(), "vector");
    end
    // Hang limit
    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            num_errors++;
            end_of_test;
        end
    end
    initial
    begin
        repeat (4) @(posedge i_clock);
        i_rstn <= 1'b1;
        for (int i = 2; i < 8; i++) apb(0, 12'(4 * i), '0, {1'b0, M, 32'h0});
        apb(1, OFS_PENDING, 32'h7FF, '0);
        apb(0, OFS_PENDING, '0, {1'b0, M, 32'h0});
        apb(0, 12'h020, '0, {1'b1, 64'h0});
        fire(1'b1, 5'h1F, 5'h1F, 1'b1);
        drain(10);
        $display("regs and mask done");
        apb(1, OFS_REQ_EN, 32'h7F9, '0);
        for (int i = 0; i < 10; i++)
        begin
            dly <= 2'($random(seed));
            exp_vec.push_back(4'(REQ_EP0 + i % 5));
            fire(1'b0, 5'(i < 5) << i % 5, 5'(i >= 5) << i % 5, 1'b0);
            drain(20);
        end
        dly <= 2'h0;
        exp_vec = {4'h0, 4'h5, 4'hA};
        fire(1'b1, 5'h04, 5'h00, 1'b1);
        drain(30);
        $display("sources done");
        apb(1, OFS_SINK_EN, 32'h28, '0);
        apb(1, OFS_SINK_POL, 32'h08, '0);
        for (int k = 0; k < 6; k++)
        begin
            if (SX[k]) exp_vec.push_back(4'h8);
            i_sink_pins <= SP[k];
            drain(20);
        end
        a = $random(seed);
        apb(1, OFS_GPIO_EN, a, '0);
        apb(1, OFS_GPIO_POL, 32'h5, '0);
        repeat (8)
        begin
            p = $unsigned($random(seed)) % 32;
            for (int f = 1; f >= 0; f--)
            begin
                if (a[p] && (p / 8 % 2 == 0) == (f == 1)) exp_vec.push_back(4'h9);
                i_gpio_pins[p] <= f[0];
                drain(20);
            end
        end
        $display("pins done");
        apb(1, OFS_REQ_EN, 32'h2, '0);
        exp_vec.push_back(4'h1);
        p = cyc;
        apb(0, OFS_TMR_LO, '0, '0);
        a = r;
        wait (cyc == p + 1001);
        apb(0, OFS_TMR_LO, '0, '0);
        chk(8'(r - a) === 8'h0A, "count rate");
        apb(0, OFS_TMR_HI, '0, '0);
        a = r;
        drain(13000);
        apb(1, OFS_REQ_EN, 32'h0, '0);
        repeat (26000) @(posedge i_clock);
        apb(0, OFS_TMR_HI, '0, {1'b0, M, a});
        apb(0, OFS_TMR_LO, '0, '0);
        apb(0, OFS_TMR_HI, '0, '0);
        chk(4'(r - a) === 4'h1 || 4'(r - a) === 4'h2, "held bits");
        $display("timer done");
        end_of_test;
    end
endmodule

// File: test/vit_core_model.sv
// Core model that takes vectors.
// Assumes a one-cycle ack taken at the clock edge.
`timescale 1ns/1ns
module vit_core_model
(
    input  logic       i_clock,
    input  logic       i_rstn,
    input  logic       i_irq,
    input  logic [3:0] i_vector,
    input  logic [1:0] i_delay,
    output logic       o_ack,
    output logic [3:0] o_ack_vec
);
    logic [1:0] cnt;
    // Wait, then pulse ack with the shown vector
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            {o_ack, o_ack_vec, cnt} <= '0;
        else if (o_ack)
            {o_ack, o_ack_vec, cnt} <= {1'b0, ~o_ack_vec, 2'h0};
        else if (i_irq && cnt == i_delay)
            {o_ack, o_ack_vec} <= {1'b1, i_vector};
        else if (i_irq)
            cnt <= cnt + 2'h1;
    end
endmodule

// File: test/vit_monitor.sv
// Checker bound to the vit_top ports.
// Assumes full-lane APB writes and the zero-wait answer.
`timescale 1ns/1ns
module vit_monitor
    import vit_pkg::*;
(
    input logic        i_clock,
    input logic        i_rstn,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    input logic        i_bus_reset,
    input logic [4:0]  i_ep_rx_done,
    input logic [4:0]  i_ep_tx_done,
    input logic        i_ser_event,
    input logic        i_ack,
    input logic [31:0] o_prdata,
    input logic        o_pready,
    input logic        o_irq,
    input logic [3:0]  o_vector
);
    logic [10:0] en;
    logic [11:0] cap;
    logic [3:0]  hi;
    logic        hi_ok;
    logic        lo_rd;
    logic        setup;
    logic        wr_en;
    // Bus phase decode; an enable write lands at its access edge
    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && i_pwrite && o_pready && i_paddr == OFS_REQ_EN;
    // Shadow enables and the last upper timer read
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            {en, cap, hi, hi_ok, lo_rd} <= '0;
        else
        begin
            if (wr_en) en <= i_pwdata[10:0];
            if (setup) cap <= i_paddr;
            if (setup && !i_pwrite && i_paddr == OFS_TMR_LO) lo_rd <= 1'b1;
            if (o_pready && cap == OFS_TMR_HI) {hi, hi_ok, lo_rd} <= {o_prdata[3:0], 2'b10};
        end
    end
    // ----------
    // Checks
    // ----------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    AST_PEND: assert property ($fell(o_irq) |-> $past(i_ack) || $past(wr_en)) else $error("irq lost");
    AST_BUS: assert property (i_bus_reset && en[0] |=> o_irq && o_vector == 4'h0) else $error("bus");
    AST_RX: assert property (|(i_ep_rx_done & en[7:3]) |=> o_irq && o_vector <= 4'h7) else $error("rx");
    AST_TX: assert property (|(i_ep_tx_done & en[7:3]) |=> o_irq && o_vector <= 4'h7) else $error("tx");
    AST_SER: assert property (i_ser_event && en[10] |-> ##1 o_irq) else $error("ser");
    AST_VEC: assert property (o_irq |-> o_vector < 4'hB) else $error("vector range");
    AST_MASK: assert property (en == '0 && $past(en) == '0 |-> !o_irq) else $error("masked irq");
    AST_HOLD: assert property (o_pready && cap == OFS_TMR_HI && hi_ok && !lo_rd |-> o_prdata[3:0] == hi)
        else $error("hold");
endmodule
bind vit_top vit_monitor i_mon (.i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_bus_reset, .i_ep_rx_done, .i_ep_tx_done, .i_ser_event, .i_ack, .o_prdata, .o_pready, .o_irq, .o_vector);
